// ---- rtl/sirq_pkg.sv ----
// Constants and types for the serial block interrupt-source logic
// Summary of operation
// RQ1: Receive-level request cannot be cleared while fill exceeds the programmed level.
// RQ2: Receive-not-empty request cannot be cleared while the FIFO holds an entry.
// RQ3: Receive-full request cannot be cleared while the FIFO is full.
// RQ4: Software set writes force chosen request bits as if events occurred.
// RQ5: Receive-level request rises whenever fill count exceeds the programmed level.
// RQ6: Software programs the level between zero and FIFO depth minus one.
// RQ7: Each group has a mask; only masked-in requests reach the interrupt.
// RQ8: Each group offers a masked view equal to request AND mask.
// RQ9: Software clears selected request bits in receive, master and slave groups.
// RQ10: Master group flags SPI done, I2C ACK, I2C NACK and I2C stop.
// RQ11: Master group flags I2C arbitration loss to another master.
// RQ12: Master bus error flags an unexpected start or stop on the bus.
// RQ13: Slave arbitration loss flags driven data differing from observed data.
// RQ14: Slave group flags ACK and NACK received from the master.
// RQ15: Slave write-stop flags stop or restart ending an addressed write.
// RQ16: Slave stop flags stop or restart ending any addressed transfer.
// RQ17: Slave group flags each received start condition.
// RQ18: Slave group flags an own-address match.
// RQ19: Slave group flags a general call address separately.
// RQ20: SPI slave error flags deselect partway through a transfer.
// RQ21: Whole block runs from one dedicated clock input.
// RQ22: All enabled asserted requests OR into one interrupt line.
// RQ23: Writing one clears a request bit; writing zero leaves it.
// RQ24: A hardware event wins over a same-cycle software clear.
package sirq_pkg;

    // Group widths
    localparam int RX_W = 7;
    localparam int MST_W = 6;
    localparam int SLV_W = 10;

    // Receive group bit positions
    localparam int RX_LEVEL_BIT = 0;
    localparam int RX_NONEMPTY_BIT = 2;
    localparam int RX_FULL_BIT = 3;
    localparam int RX_OVERFLOW_BIT = 5;
    localparam int RX_UNDERFLOW_BIT = 6;
    localparam int RX_FRAME_ERR_BIT = 8 - 7;
    localparam int RX_PARITY_ERR_BIT = 4;

    // Master group bit positions
    localparam int MST_SPI_DONE_BIT = 0;
    localparam int MST_ARB_LOST_BIT = 1;
    localparam int MST_NACK_BIT = 2;
    localparam int MST_ACK_BIT = 3;
    localparam int MST_STOP_BIT = 4;
    localparam int MST_BUS_ERR_BIT = 5;

    // Slave group bit positions
    localparam int SLV_ARB_LOST_BIT = 0;
    localparam int SLV_NACK_BIT = 1;
    localparam int SLV_ACK_BIT = 2;
    localparam int SLV_WR_STOP_BIT = 3;
    localparam int SLV_STOP_BIT = 4;
    localparam int SLV_START_BIT = 5;
    localparam int SLV_ADDR_HIT_BIT = 6;
    localparam int SLV_GENCALL_BIT = 7;
    localparam int SLV_BUS_ERR_BIT = 8;
    localparam int SLV_SPI_DESEL_ERR_BIT = 9;

    // Reset values
    localparam logic [RX_W-1:0] RX_REQ_RST = 7'h00;
    localparam logic [RX_W-1:0] RX_MASK_RST = 7'h00;
    localparam logic [MST_W-1:0] MST_REQ_RST = 6'h00;
    localparam logic [MST_W-1:0] MST_MASK_RST = 6'h00;
    localparam logic [SLV_W-1:0] SLV_REQ_RST = 10'h000;
    localparam logic [SLV_W-1:0] SLV_MASK_RST = 10'h000;

    // Default FIFO depth
    localparam int RX_DEPTH_DEF = 8;

    // Slave I2C transfer tracking states
    typedef enum logic [1:0] {
        SIRQ_SLV_IDLE,
        SIRQ_SLV_ADDR,
        SIRQ_SLV_WRITE,
        SIRQ_SLV_READ
    } sirq_slv_state_t;

endpackage

// ---- rtl/sirq_grp_if.sv ----
// Interface carrying one request group's control between top and group module
`timescale 1ns/1ps
interface sirq_grp_if #(
    parameter int W = 8
);
    logic [W-1:0] event_set;
    logic [W-1:0] hold_set;
    logic [W-1:0] sw_set;
    logic [W-1:0] sw_clr;
    logic [W-1:0] sw_mask;
    logic sw_mask_we;
    logic [W-1:0] req;
    logic [W-1:0] mask;
    logic [W-1:0] masked;
    logic any;

    modport ctrl (
        output event_set, hold_set, sw_set, sw_clr, sw_mask, sw_mask_we,
        input req, mask, masked, any
    );
    modport grp (
        input event_set, hold_set, sw_set, sw_clr, sw_mask, sw_mask_we,
        output req, mask, masked, any
    );
endinterface

// ---- rtl/sirq_group.sv ----
// One interrupt group: request, mask and masked view
`timescale 1ns/1ps
module sirq_group
    import sirq_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] REQ_RST = '0,
    parameter logic [W-1:0] MASK_RST = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Group control
    sirq_grp_if.grp g
);
    logic [W-1:0] req_r;
    logic [W-1:0] mask_r;

    // Events and held levels win over clear; one clears, zero keeps
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_r <= REQ_RST;
        end else begin
            req_r <= (req_r & ~g.sw_clr) | g.sw_set | g.event_set | g.hold_set; // RQ4 RQ9 RQ23 RQ24
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mask_r <= MASK_RST;
        end else if (g.sw_mask_we) begin
            mask_r <= g.sw_mask; // RQ7
        end
    end

    assign g.req = req_r;
    assign g.mask = mask_r;
    assign g.masked = req_r & mask_r; // RQ8
    assign g.any = |(req_r & mask_r); // RQ7
endmodule

// ---- rtl/sirq_top.sv ----
// Interrupt-source logic for the multi-protocol serial block
`timescale 1ns/1ps
module sirq_top
    import sirq_pkg::*;
#(
    parameter int RX_DEPTH = RX_DEPTH_DEF,
    parameter int CNT_W = $clog2(RX_DEPTH + 1)
) (
    // Single dedicated block clock and reset
    input wire logic core_clk,
    input wire logic reset,

    // Receive FIFO state and events
    input wire logic [CNT_W-1:0] rx_fill_count,
    input wire logic [CNT_W-1:0] rx_level,
    input wire logic rx_overflow_evt,
    input wire logic rx_underflow_evt,
    input wire logic rx_frame_err_evt,
    input wire logic rx_parity_err_evt,

    // SPI master/slave status
    input wire logic spi_mst_done_evt,
    input wire logic spi_slv_active,
    input wire logic spi_slv_select,

    // I2C master events
    input wire logic i2c_mst_active,
    input wire logic i2c_mst_lost_evt,
    input wire logic i2c_mst_ack_evt,
    input wire logic i2c_mst_nack_evt,
    input wire logic i2c_mst_stop_gen_evt,
    input wire logic i2c_mst_expect_cond,

    // I2C slave bus observation
    input wire logic i2c_start_det,
    input wire logic i2c_stop_det,
    input wire logic i2c_slv_expect_cond,
    input wire logic i2c_sda_out,
    input wire logic i2c_sda_oe,
    input wire logic i2c_sda_in,
    input wire logic i2c_sda_sample,
    input wire logic i2c_addr_done,
    input wire logic i2c_addr_own,
    input wire logic i2c_addr_gencall,
    input wire logic i2c_addr_read,
    input wire logic i2c_slv_ack_evt,
    input wire logic i2c_slv_nack_evt,

    // Software access: receive group
    input wire logic [RX_W-1:0] rx_sw_set,
    input wire logic [RX_W-1:0] rx_sw_clr,
    input wire logic [RX_W-1:0] rx_sw_mask,
    input wire logic rx_sw_mask_we,

    // Software access: master group
    input wire logic [MST_W-1:0] mst_sw_set,
    input wire logic [MST_W-1:0] mst_sw_clr,
    input wire logic [MST_W-1:0] mst_sw_mask,
    input wire logic mst_sw_mask_we,

    // Software access: slave group
    input wire logic [SLV_W-1:0] slv_sw_set,
    input wire logic [SLV_W-1:0] slv_sw_clr,
    input wire logic [SLV_W-1:0] slv_sw_mask,
    input wire logic slv_sw_mask_we,

    // Register views
    output logic [RX_W-1:0] rx_req,
    output logic [RX_W-1:0] rx_mask,
    output logic [RX_W-1:0] rx_masked,
    output logic [MST_W-1:0] mst_req,
    output logic [MST_W-1:0] mst_mask,
    output logic [MST_W-1:0] mst_masked,
    output logic [SLV_W-1:0] slv_req,
    output logic [SLV_W-1:0] slv_mask,
    output logic [SLV_W-1:0] slv_masked,

    // Combined interrupt request
    output logic irq
);
    sirq_grp_if #(.W(RX_W)) rx_g ();
    sirq_grp_if #(.W(MST_W)) mst_g ();
    sirq_grp_if #(.W(SLV_W)) slv_g ();

    // Receive level conditions
    logic rx_level_src;
    logic rx_nonempty_src;
    logic rx_full_src;

    assign rx_level_src = rx_fill_count > rx_level; // RQ5 RQ6
    assign rx_nonempty_src = rx_fill_count != '0;
    assign rx_full_src = rx_fill_count == CNT_W'(RX_DEPTH);

    // Receive group wiring
    always_comb begin
        rx_g.hold_set = '0;
        rx_g.hold_set[RX_LEVEL_BIT] = rx_level_src; // RQ1 RQ5
        rx_g.hold_set[RX_NONEMPTY_BIT] = rx_nonempty_src; // RQ2
        rx_g.hold_set[RX_FULL_BIT] = rx_full_src; // RQ3
        rx_g.event_set = '0;
        rx_g.event_set[RX_OVERFLOW_BIT] = rx_overflow_evt;
        rx_g.event_set[RX_UNDERFLOW_BIT] = rx_underflow_evt;
        rx_g.event_set[RX_FRAME_ERR_BIT] = rx_frame_err_evt;
        rx_g.event_set[RX_PARITY_ERR_BIT] = rx_parity_err_evt;
    end
    assign rx_g.sw_set = rx_sw_set; // RQ4
    assign rx_g.sw_clr = rx_sw_clr; // RQ9
    assign rx_g.sw_mask = rx_sw_mask;
    assign rx_g.sw_mask_we = rx_sw_mask_we;

    // Master events
    logic mst_spi_done_src;
    logic mst_arb_lost_src;
    logic mst_nack_src;
    logic mst_ack_src;
    logic mst_stop_src;
    logic mst_bus_err_src;

    assign mst_spi_done_src = spi_mst_done_evt; // RQ10
    assign mst_ack_src = i2c_mst_ack_evt; // RQ10
    assign mst_nack_src = i2c_mst_nack_evt; // RQ10
    assign mst_stop_src = i2c_mst_stop_gen_evt; // RQ10
    assign mst_arb_lost_src = i2c_mst_active & i2c_mst_lost_evt; // RQ11
    // Start or stop seen while the master engine did not expect one
    assign mst_bus_err_src = i2c_mst_active & (i2c_start_det | i2c_stop_det)
                             & ~i2c_mst_expect_cond; // RQ12

    always_comb begin
        mst_g.event_set = '0;
        mst_g.event_set[MST_SPI_DONE_BIT] = mst_spi_done_src;
        mst_g.event_set[MST_ARB_LOST_BIT] = mst_arb_lost_src;
        mst_g.event_set[MST_NACK_BIT] = mst_nack_src;
        mst_g.event_set[MST_ACK_BIT] = mst_ack_src;
        mst_g.event_set[MST_STOP_BIT] = mst_stop_src;
        mst_g.event_set[MST_BUS_ERR_BIT] = mst_bus_err_src;
    end
    assign mst_g.hold_set = '0;
    assign mst_g.sw_set = mst_sw_set; // RQ4
    assign mst_g.sw_clr = mst_sw_clr; // RQ9
    assign mst_g.sw_mask = mst_sw_mask;
    assign mst_g.sw_mask_we = mst_sw_mask_we;

    // Slave transfer tracking: which transfer matched our address
    sirq_slv_state_t slv_state_r;
    sirq_slv_state_t slv_state_nxt;
    logic slv_hit;
    logic slv_end;

    assign slv_hit = i2c_addr_done & (i2c_addr_own | i2c_addr_gencall);
    assign slv_end = i2c_stop_det | i2c_start_det;

    always_comb begin
        slv_state_nxt = slv_state_r;
        case (slv_state_r)
            SIRQ_SLV_IDLE: begin
                if (i2c_start_det) begin
                    slv_state_nxt = SIRQ_SLV_ADDR;
                end
            end
            SIRQ_SLV_ADDR: begin
                if (i2c_stop_det) begin
                    slv_state_nxt = SIRQ_SLV_IDLE;
                end else if (slv_hit) begin
                    slv_state_nxt = i2c_addr_read ? SIRQ_SLV_READ : SIRQ_SLV_WRITE;
                end else if (i2c_addr_done) begin
                    slv_state_nxt = SIRQ_SLV_IDLE;
                end
            end
            SIRQ_SLV_WRITE, SIRQ_SLV_READ: begin
                if (i2c_stop_det) begin
                    slv_state_nxt = SIRQ_SLV_IDLE;
                end else if (i2c_start_det) begin
                    slv_state_nxt = SIRQ_SLV_ADDR;
                end
            end
            default: begin
                slv_state_nxt = SIRQ_SLV_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            slv_state_r <= SIRQ_SLV_IDLE;
        end else begin
            slv_state_r <= slv_state_nxt;
        end
    end

    // SPI slave: remember an active transfer to catch early deselect
    logic spi_busy_r;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            spi_busy_r <= 1'b0;
        end else begin
            spi_busy_r <= spi_slv_select & spi_slv_active;
        end
    end

    // Slave events
    logic slv_arb_lost_src;
    logic slv_nack_src;
    logic slv_ack_src;
    logic slv_wr_stop_src;
    logic slv_stop_src;
    logic slv_start_src;
    logic slv_addr_hit_src;
    logic slv_gencall_src;
    logic slv_bus_err_src;
    logic slv_spi_desel_err_src;
    logic slv_in_xfer;

    assign slv_in_xfer = (slv_state_r == SIRQ_SLV_WRITE) | (slv_state_r == SIRQ_SLV_READ);
    // Released bus (high) while we drive low counts too
    assign slv_arb_lost_src = i2c_sda_sample & i2c_sda_oe & (i2c_sda_out != i2c_sda_in); // RQ13
    assign slv_ack_src = i2c_slv_ack_evt; // RQ14
    assign slv_nack_src = i2c_slv_nack_evt; // RQ14
    assign slv_wr_stop_src = (slv_state_r == SIRQ_SLV_WRITE) & slv_end; // RQ15
    assign slv_stop_src = slv_in_xfer & slv_end; // RQ16
    assign slv_start_src = i2c_start_det; // RQ17
    assign slv_addr_hit_src = i2c_addr_done & i2c_addr_own; // RQ18
    assign slv_gencall_src = i2c_addr_done & i2c_addr_gencall; // RQ19
    assign slv_bus_err_src = slv_in_xfer & slv_end & ~i2c_slv_expect_cond;
    assign slv_spi_desel_err_src = spi_busy_r & ~spi_slv_select; // RQ20

    always_comb begin
        slv_g.event_set = '0;
        slv_g.event_set[SLV_ARB_LOST_BIT] = slv_arb_lost_src;
        slv_g.event_set[SLV_NACK_BIT] = slv_nack_src;
        slv_g.event_set[SLV_ACK_BIT] = slv_ack_src;
        slv_g.event_set[SLV_WR_STOP_BIT] = slv_wr_stop_src;
        slv_g.event_set[SLV_STOP_BIT] = slv_stop_src;
        slv_g.event_set[SLV_START_BIT] = slv_start_src;
        slv_g.event_set[SLV_ADDR_HIT_BIT] = slv_addr_hit_src;
        slv_g.event_set[SLV_GENCALL_BIT] = slv_gencall_src;
        slv_g.event_set[SLV_BUS_ERR_BIT] = slv_bus_err_src;
        slv_g.event_set[SLV_SPI_DESEL_ERR_BIT] = slv_spi_desel_err_src;
    end
    assign slv_g.hold_set = '0;
    assign slv_g.sw_set = slv_sw_set; // RQ4
    assign slv_g.sw_clr = slv_sw_clr; // RQ9
    assign slv_g.sw_mask = slv_sw_mask;
    assign slv_g.sw_mask_we = slv_sw_mask_we;

    // Group register instances, all on the one block clock
    sirq_group #(.W(RX_W), .REQ_RST(RX_REQ_RST), .MASK_RST(RX_MASK_RST)) u_rx (
        .core_clk(core_clk), // RQ21
        .reset(reset),
        .g(rx_g)
    );
    sirq_group #(.W(MST_W), .REQ_RST(MST_REQ_RST), .MASK_RST(MST_MASK_RST)) u_mst (
        .core_clk(core_clk),
        .reset(reset),
        .g(mst_g)
    );
    sirq_group #(.W(SLV_W), .REQ_RST(SLV_REQ_RST), .MASK_RST(SLV_MASK_RST)) u_slv (
        .core_clk(core_clk),
        .reset(reset),
        .g(slv_g)
    );

    assign rx_req = rx_g.req;
    assign rx_mask = rx_g.mask;
    assign rx_masked = rx_g.masked;
    assign mst_req = mst_g.req;
    assign mst_mask = mst_g.mask;
    assign mst_masked = mst_g.masked;
    assign slv_req = slv_g.req;
    assign slv_mask = slv_g.mask;
    assign slv_masked = slv_g.masked;

    assign irq = rx_g.any | mst_g.any | slv_g.any; // RQ22
endmodule

// ---- tb/sirq_top_checker.sv ----
// Concurrent checks on the interrupt-source block ports
`timescale 1ns/1ps
module sirq_top_checker
    import sirq_pkg::*;
#(
    parameter int RX_DEPTH = RX_DEPTH_DEF,
    parameter int CNT_W = $clog2(RX_DEPTH + 1)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Sources
    input wire logic [CNT_W-1:0] rx_fill_count,
    input wire logic [CNT_W-1:0] rx_level,
    input wire logic spi_mst_done_evt,
    input wire logic spi_slv_active,
    input wire logic spi_slv_select,
    input wire logic i2c_mst_active,
    input wire logic i2c_mst_lost_evt,
    input wire logic i2c_mst_ack_evt,
    input wire logic i2c_mst_nack_evt,
    input wire logic i2c_mst_stop_gen_evt,
    input wire logic i2c_start_det,
    input wire logic i2c_stop_det,
    input wire logic i2c_addr_done,
    input wire logic i2c_addr_own,
    // Software access
    input wire logic [MST_W-1:0] mst_sw_set,
    input wire logic [MST_W-1:0] mst_sw_clr,
    input wire logic [MST_W-1:0] mst_sw_mask,
    input wire logic mst_sw_mask_we,
    // Views
    input wire logic [RX_W-1:0] rx_req,
    input wire logic [RX_W-1:0] rx_mask,
    input wire logic [RX_W-1:0] rx_masked,
    input wire logic [MST_W-1:0] mst_req,
    input wire logic [MST_W-1:0] mst_mask,
    input wire logic [MST_W-1:0] mst_masked,
    input wire logic [SLV_W-1:0] slv_req,
    input wire logic [SLV_W-1:0] slv_mask,
    input wire logic [SLV_W-1:0] slv_masked,
    input wire logic irq
);
    logic mst_quiet;

    // No master-group source competes with a clear
    assign mst_quiet = !(spi_mst_done_evt | i2c_mst_lost_evt | i2c_mst_ack_evt | i2c_mst_nack_evt
        | i2c_mst_stop_gen_evt | i2c_start_det | i2c_stop_det) && (mst_sw_set == '0);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_masked_view: assert property ({rx_masked, mst_masked, slv_masked} ==
        ({rx_req, mst_req, slv_req} & {rx_mask, mst_mask, slv_mask}))
        else $error("masked view differs from request and mask");
    chk_irq_or: assert property (irq == |{rx_masked, mst_masked, slv_masked})
        else $error("irq differs from OR of masked bits");
    chk_level_hold: assert property ((rx_fill_count > rx_level) |=> rx_req[RX_LEVEL_BIT])
        else $error("receive level request missing");
    chk_nonempty_hold: assert property ((rx_fill_count != 0) |=> rx_req[RX_NONEMPTY_BIT])
        else $error("receive not-empty request missing");
    chk_full_hold: assert property ((rx_fill_count == CNT_W'(RX_DEPTH)) |=> rx_req[RX_FULL_BIT])
        else $error("receive full request missing");
    chk_sw_set_forces: assert property (|mst_sw_set |=>
        ((mst_req & $past(mst_sw_set)) == $past(mst_sw_set)))
        else $error("software set did not take");
    chk_clr_one: assert property ((mst_sw_clr != '0) && mst_quiet |=>
        ((mst_req & $past(mst_sw_clr)) == '0))
        else $error("write-one clear did not take");
    chk_zero_keeps: assert property (!$past(reset) |-> ((mst_req & $past(mst_req) &
        ~$past(mst_sw_clr)) == ($past(mst_req) & ~$past(mst_sw_clr))))
        else $error("request bit fell without a clear");
    chk_evt_wins: assert property (spi_mst_done_evt |=> mst_req[MST_SPI_DONE_BIT])
        else $error("transfer done request lost");
    chk_arb_lost: assert property (i2c_mst_active && i2c_mst_lost_evt |=> mst_req[MST_ARB_LOST_BIT])
        else $error("arbitration loss not flagged");
    chk_mask_load: assert property (mst_sw_mask_we |=> (mst_mask == $past(mst_sw_mask)))
        else $error("mask write not loaded");
    chk_desel_err: assert property ((spi_slv_select && spi_slv_active) ##1 !spi_slv_select
        |=> slv_req[SLV_SPI_DESEL_ERR_BIT])
        else $error("deselect error not flagged");
    chk_start_flag: assert property (i2c_start_det |=> slv_req[SLV_START_BIT])
        else $error("start not flagged");
    chk_addr_hit: assert property (i2c_addr_done && i2c_addr_own |=> slv_req[SLV_ADDR_HIT_BIT])
        else $error("address match not flagged");

    cov_rx_full: cover property (rx_fill_count == CNT_W'(RX_DEPTH));
    cov_irq: cover property ($rose(irq));
    cov_evt_clr: cover property (spi_mst_done_evt && mst_sw_clr[MST_SPI_DONE_BIT]);
endmodule

bind sirq_top sirq_top_checker #(.RX_DEPTH(RX_DEPTH), .CNT_W(CNT_W)) u_chk (.*);

// ---- tb/tb_sirq_top.sv ----
// Self-checking bench for the interrupt-source block
`timescale 1ns/1ps
module tb_sirq_top
    import sirq_pkg::*;
;
    localparam int DEP = 4;
    localparam int CW = $clog2(DEP + 1);
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [CW-1:0] rx_fill_count, rx_level;
    logic rx_overflow_evt, rx_underflow_evt, rx_frame_err_evt, rx_parity_err_evt;
    logic spi_mst_done_evt, spi_slv_active, spi_slv_select, i2c_mst_active, i2c_mst_lost_evt;
    logic i2c_mst_ack_evt, i2c_mst_nack_evt, i2c_mst_stop_gen_evt, i2c_mst_expect_cond;
    logic i2c_start_det, i2c_stop_det, i2c_slv_expect_cond, i2c_sda_out, i2c_sda_oe;
    logic i2c_sda_in, i2c_sda_sample, i2c_addr_done, i2c_addr_own, i2c_addr_gencall;
    logic i2c_addr_read, i2c_slv_ack_evt, i2c_slv_nack_evt, irq;
    logic [RX_W-1:0] rx_sw_set, rx_sw_clr, rx_sw_mask, rx_req, rx_mask, rx_masked;
    logic [MST_W-1:0] mst_sw_set, mst_sw_clr, mst_sw_mask, mst_req, mst_mask, mst_masked;
    logic [SLV_W-1:0] slv_sw_set, slv_sw_clr, slv_sw_mask, slv_req, slv_mask, slv_masked;
    logic rx_sw_mask_we, mst_sw_mask_we, slv_sw_mask_we;
    int miscompares = 0;
    int check_count = 0;

    always #2.5 core_clk = ~core_clk;

    sirq_top #(.RX_DEPTH(DEP), .CNT_W(CW)) DUT (.*);

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic clear_all();
        @(posedge core_clk);
        rx_fill_count <= '0;
        {rx_sw_clr, mst_sw_clr, slv_sw_clr} <= '1;
        @(posedge core_clk);
        {rx_sw_clr, mst_sw_clr, slv_sw_clr} <= '0;
        #1 cmp(32'({rx_req, mst_req, slv_req}), 32'h0);
    endtask

    task automatic t_set_clr_mask();
        @(posedge core_clk);
        {rx_sw_set, mst_sw_set, slv_sw_set} <= '1;
        @(posedge core_clk);
        {rx_sw_set, mst_sw_set, slv_sw_set} <= '0;
        #1 cmp(32'({rx_req, mst_req, slv_req}), 32'h007FFFFF);
        @(posedge core_clk);
        {rx_sw_clr, mst_sw_clr, slv_sw_clr} <= {7'h2A, 6'h2A, 10'h2AA};
        {rx_sw_mask, mst_sw_mask, slv_sw_mask} <= {7'h2A, 6'h2A, 10'h2AA};
        {rx_sw_mask_we, mst_sw_mask_we, slv_sw_mask_we} <= 3'h7;
        @(posedge core_clk);
        {rx_sw_clr, mst_sw_clr, slv_sw_clr} <= '0;
        {rx_sw_mask_we, mst_sw_mask_we, slv_sw_mask_we} <= 3'h0;
        #1 cmp(32'({rx_req, mst_req, slv_req}), 32'({7'h55, 6'h15, 10'h155}));
        cmp(32'({rx_masked, mst_masked, slv_masked, irq}), 32'h0);
        cmp(32'({rx_mask, mst_mask, slv_mask}), 32'({7'h2A, 6'h2A, 10'h2AA}));
        @(posedge core_clk);
        mst_sw_mask <= 6'h03;
        mst_sw_mask_we <= 1'h1;
        @(posedge core_clk);
        mst_sw_mask_we <= 1'h0;
        #1 cmp(32'({mst_mask, mst_masked, irq}), 32'({6'h03, 6'h01, 1'h1}));
        clear_all();
        cmp(32'(irq), 32'h0);
    endtask

    task automatic t_rx_held();
        @(posedge core_clk);
        rx_level <= CW'(3);
        rx_fill_count <= CW'(3);
        @(posedge core_clk);
        rx_fill_count <= CW'(DEP);
        #1 cmp(32'(rx_req), 32'(1 << RX_NONEMPTY_BIT));
        @(posedge core_clk);
        rx_sw_clr <= '1;
        @(posedge core_clk);
        rx_sw_clr <= '0;
        #1 cmp(32'(rx_req), 32'((1 << RX_NONEMPTY_BIT) | (1 << RX_LEVEL_BIT) | (1 << RX_FULL_BIT)));
        clear_all();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {rx_parity_err_evt, rx_frame_err_evt, rx_underflow_evt, rx_overflow_evt} <= 4'h1 << i;
        end
        @(posedge core_clk);
        {rx_parity_err_evt, rx_frame_err_evt, rx_underflow_evt, rx_overflow_evt} <= 4'h0;
        #1 cmp(32'(rx_req), 32'((1 << RX_OVERFLOW_BIT) | (1 << RX_UNDERFLOW_BIT)
            | (1 << RX_FRAME_ERR_BIT) | (1 << RX_PARITY_ERR_BIT)));
        clear_all();
    endtask

    task automatic t_master();
        @(posedge core_clk);
        spi_mst_done_evt <= 1'h1;
        mst_sw_clr <= '1;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            {spi_mst_done_evt, mst_sw_clr} <= '0;
            {i2c_mst_stop_gen_evt, i2c_mst_ack_evt, i2c_mst_nack_evt} <= 3'h1 << i;
        end
        @(posedge core_clk);
        {i2c_mst_stop_gen_evt, i2c_mst_ack_evt, i2c_mst_nack_evt} <= 3'h0;
        #1 cmp(32'(mst_req), 32'((1 << MST_SPI_DONE_BIT) | (1 << MST_NACK_BIT)
            | (1 << MST_ACK_BIT) | (1 << MST_STOP_BIT)));
        clear_all();
        @(posedge core_clk);
        i2c_mst_active <= 1'h1;
        i2c_mst_lost_evt <= 1'h1;
        i2c_mst_expect_cond <= 1'h1;
        @(posedge core_clk);
        i2c_mst_lost_evt <= 1'h0;
        i2c_start_det <= 1'h1;
        @(posedge core_clk);
        i2c_start_det <= 1'h0;
        #1 cmp(32'(mst_req), 32'(1 << MST_ARB_LOST_BIT));
        cmp(32'(slv_req), 32'(1 << SLV_START_BIT));
        @(posedge core_clk);
        i2c_mst_expect_cond <= 1'h0;
        i2c_stop_det <= 1'h1;
        @(posedge core_clk);
        i2c_stop_det <= 1'h0;
        i2c_mst_active <= 1'h0;
        #1 cmp(32'(mst_req), 32'((1 << MST_ARB_LOST_BIT) | (1 << MST_BUS_ERR_BIT)));
        clear_all();
    endtask

    task automatic t_slave();
        @(posedge core_clk);
        i2c_start_det <= 1'h1;
        i2c_slv_expect_cond <= 1'h1;
        @(posedge core_clk);
        i2c_start_det <= 1'h0;
        {i2c_addr_done, i2c_addr_own} <= 2'h3;
        @(posedge core_clk);
        {i2c_addr_done, i2c_addr_own} <= 2'h0;
        {i2c_slv_ack_evt, i2c_slv_nack_evt} <= 2'h3;
        @(posedge core_clk);
        {i2c_slv_ack_evt, i2c_slv_nack_evt} <= 2'h0;
        i2c_start_det <= 1'h1;
        @(posedge core_clk);
        i2c_start_det <= 1'h0;
        slv_sw_clr <= '1;
        #1 cmp(32'(slv_req), 32'((1 << SLV_START_BIT) | (1 << SLV_ADDR_HIT_BIT) | (1 << SLV_ACK_BIT)
            | (1 << SLV_NACK_BIT) | (1 << SLV_WR_STOP_BIT) | (1 << SLV_STOP_BIT)));
        @(posedge core_clk);
        slv_sw_clr <= '0;
        {i2c_addr_done, i2c_addr_gencall, i2c_addr_read} <= 3'h7;
        @(posedge core_clk);
        {i2c_addr_done, i2c_addr_gencall, i2c_addr_read} <= 3'h0;
        i2c_stop_det <= 1'h1;
        i2c_slv_expect_cond <= 1'h0;
        @(posedge core_clk);
        i2c_stop_det <= 1'h0;
        #1 cmp(32'(slv_req), 32'((1 << SLV_GENCALL_BIT) | (1 << SLV_STOP_BIT)
            | (1 << SLV_BUS_ERR_BIT)));
        clear_all();
        @(posedge core_clk);
        {i2c_sda_oe, i2c_sda_out, i2c_sda_sample, i2c_sda_in} <= 4'hE;
        {spi_slv_select, spi_slv_active} <= 2'h3;
        @(posedge core_clk);
        {i2c_sda_oe, i2c_sda_out, i2c_sda_sample, i2c_sda_in} <= 4'h0;
        {spi_slv_select, spi_slv_active} <= 2'h0;
        repeat (2) @(posedge core_clk);
        #1 cmp(32'(slv_req), 32'((1 << SLV_ARB_LOST_BIT) | (1 << SLV_SPI_DESEL_ERR_BIT)));
    endtask

    initial begin
        #100000;
        miscompares++;
        close_out();
    end

    initial begin
        {rx_fill_count, rx_level, rx_overflow_evt, rx_underflow_evt, rx_frame_err_evt,
            rx_parity_err_evt, spi_mst_done_evt, spi_slv_active, spi_slv_select, i2c_mst_active,
            i2c_mst_lost_evt, i2c_mst_ack_evt, i2c_mst_nack_evt, i2c_mst_stop_gen_evt,
            i2c_mst_expect_cond, i2c_start_det, i2c_stop_det, i2c_slv_expect_cond, i2c_sda_out,
            i2c_sda_oe, i2c_sda_in, i2c_sda_sample, i2c_addr_done, i2c_addr_own, i2c_addr_gencall,
            i2c_addr_read, i2c_slv_ack_evt, i2c_slv_nack_evt, rx_sw_set, rx_sw_clr, rx_sw_mask,
            rx_sw_mask_we, mst_sw_set, mst_sw_clr, mst_sw_mask, mst_sw_mask_we, slv_sw_set,
            slv_sw_clr, slv_sw_mask, slv_sw_mask_we} = '0;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1 cmp(32'({rx_req, mst_req, slv_req, irq}), 32'h0);
        cmp(32'({rx_mask, mst_mask, slv_mask}), 32'h0);
        t_set_clr_mask();
        t_rx_held();
        t_master();
        t_slave();
        close_out();
    end
endmodule
